/* logic/dss_regs.svh */
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH

// Oscillator pulses per converter count
`define DSS_PRESCALE      4
// Oscillator pulses per backplane period
`define DSS_BP_DIV        800
// Counts of signal integrate
`define DSS_INT_COUNTS    1000
// Longest de-integrate, also the full-scale reading
`define DSS_DEINT_MAX     2000
// Counts of one whole measurement cycle
`define DSS_CYCLE_COUNTS  4000
// Decade counter digits, thousands included
`define DSS_DIGITS        4

`endif

/* logic/dss_pkg.sv */
package dss_pkg;

  typedef enum logic [1:0] {
    DSS_PH_AZ    = 2'b00,
    DSS_PH_INT   = 2'b01,
    DSS_PH_DEINT = 2'b10
  } dss_phase_t;

  // Analog switch controls for the integrator front end
  typedef struct packed {
    logic auto_zero;
    logic sig_integrate;
    logic de_integrate;
    logic ref_negative;
  } dss_ctrl_t;

  // Segment bits are gfedcba per full digit
  typedef struct packed {
    logic       sign;
    logic       one;
    logic [6:0] hundreds;
    logic [6:0] tens;
    logic [6:0] units;
  } dss_seg_t;

endpackage

/* logic/dss_bcd_counter.sv */
module dss_bcd_counter #(
  parameter int DIGITS = 4
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  clear_i,
  input  wire logic                  inc_i,
  output logic      [4*DIGITS-1:0]   value_o
);
  import dss_pkg::*;

  logic [DIGITS:0] carry;

  assign carry[0] = inc_i;

  for (genvar d = 0; d < DIGITS; d++)
  begin : g_digit
    logic [3:0] digit_reg;
    wire        at_nine = (digit_reg == 4'h9);

    assign carry[d+1]        = carry[d] && at_nine;
    assign value_o[4*d +: 4] = digit_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        digit_reg <= 4'h0;
      else if (clear_i)
        digit_reg <= 4'h0;
      else if (carry[d])
        digit_reg <= at_nine ? 4'h0 : digit_reg + 4'h1;
    end
  end

  if (DIGITS < 1)
  begin : g_bad
    $error("dss_bcd_counter needs at least one digit");
  end
endmodule // dss_bcd_counter

/* logic/dss_seg_decode.sv */
module dss_seg_decode (
  input  wire logic [3:0] bcd_i,
  input  wire logic       blank_i,
  output logic      [6:0] seg_o
);
  import dss_pkg::*;

  logic [6:0] pattern;

  // Non-decimal codes cannot come from the counter, shown dark
  always_comb
  begin
    unique case (bcd_i)
      4'h0:    pattern = 7'h3F;
      4'h1:    pattern = 7'h06;
      4'h2:    pattern = 7'h5B;
      4'h3:    pattern = 7'h4F;
      4'h4:    pattern = 7'h66;
      4'h5:    pattern = 7'h6D;
      4'h6:    pattern = 7'h7D;
      4'h7:    pattern = 7'h07;
      4'h8:    pattern = 7'h7F;
      4'h9:    pattern = 7'h6F;
      default: pattern = 7'h00;
    endcase
  end

  assign seg_o = blank_i ? 7'h00 : pattern;
endmodule // dss_seg_decode

/* logic/dss_top.sv */
`include "dss_regs.svh"

// Functional notes
// - Lamp test high lights every segment so the display reads -1888.
// - The LCD backplane is a square wave at the clock divided by 800.
// - LCD segments follow the backplane when off and invert it when on.
// - The LED build has no backplane and sinks current low on lit segments.
// - The sign segment is lit for a negative input and dark for positive.
// - A divide-by-four prescaler makes one count per four clocks.
// - Integrate is 1000 counts, de-integrate 1 to 2000, auto-zero 1000-2999.
// - Unused de-integrate counts go to auto-zero, so a cycle is 4000 counts.
// - The de-integrate count is the reading, full scale being 2000.
// - Hold high keeps converting but freezes the display latch.
// - Hold is weakly pulled inactive so an open pin means live updates.
// - The half digit is one output driving both segments of the one.
// - The integrator sign at the end of integrate picks reference and sign.
// - The reading is the de-integrate count gathered in decade counters.
module dss_top #(
  parameter bit LCD_VARIANT  = 1'b1,
  parameter int PRESCALE     = `DSS_PRESCALE,
  parameter int BP_DIV       = `DSS_BP_DIV,
  parameter int INT_COUNTS   = `DSS_INT_COUNTS,
  parameter int DEINT_MAX    = `DSS_DEINT_MAX,
  parameter int CYCLE_COUNTS = `DSS_CYCLE_COUNTS
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            lamp_test_i,
  input  wire logic            hold_reading_input_i,
  input  wire logic            integ_zero_i,
  input  wire logic            integ_negative_i,
  output dss_pkg::dss_ctrl_t   ctrl_o,
  output dss_pkg::dss_seg_t    seg_o,
  output logic                 backplane_drive_o
);
  import dss_pkg::*;

  localparam int DIGITS = `DSS_DIGITS;
  localparam int PW     = $clog2(PRESCALE);
  localparam int CW     = $clog2(CYCLE_COUNTS);
  localparam int DW     = $clog2(DEINT_MAX + 1);
  localparam int BW     = $clog2(BP_DIV / 2);
  localparam int SEGW   = $bits(dss_seg_t);

  localparam logic [PW-1:0] PRE_LAST   = PW'(PRESCALE - 1);
  localparam logic [CW-1:0] INT_LAST   = CW'(INT_COUNTS - 1);
  localparam logic [CW-1:0] CYC_LAST   = CW'(CYCLE_COUNTS - 1);
  localparam logic [DW-1:0] DEINT_LAST = DW'(DEINT_MAX - 1);
  localparam logic [BW-1:0] BP_LAST    = BW'(BP_DIV / 2 - 1);

  if (PRESCALE < 2 || BP_DIV < 4 || (BP_DIV % 2) != 0 ||
      INT_COUNTS < 1 || DEINT_MAX < 1 ||
      INT_COUNTS + DEINT_MAX >= CYCLE_COUNTS)
  begin : g_bad
    $error("dss_top parameters cannot form a measurement cycle");
  end

  // Only a lone one shows the thousands, so full scale is the ceiling
  if (DEINT_MAX > `DSS_DEINT_MAX)
  begin : g_bad_disp
    $error("dss_top reading exceeds what the display can show");
  end

  // Pin synchronisers: lamp test, hold, zero crossing, sign
  logic [3:0] sync_a_reg;
  logic [3:0] sync_b_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_a_reg <= 4'h0;
    else
      sync_a_reg <= {lamp_test_i, hold_reading_input_i,
                     integ_zero_i, integ_negative_i};
  end

  // Only the second stage feeds logic; the first may be metastable
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_b_reg <= 4'h0;
    else
      sync_b_reg <= sync_a_reg;
  end

  wire lamp_s  = sync_b_reg[3];
  // Open pin is pulled low at the pad; reset value matches it
  wire hold_s  = sync_b_reg[2];
  wire zero_s  = sync_b_reg[1];
  wire neg_s   = sync_b_reg[0];

  // Prescaler
  logic [PW-1:0] pre_reg;
  wire           count_en = (pre_reg == PRE_LAST);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pre_reg <= '0;
    else
      pre_reg <= count_en ? '0 : pre_reg + PW'(1);
  end

  // Phase sequencer
  dss_phase_t    state_reg;
  dss_phase_t    state_next;
  logic [CW-1:0] cyc_reg;
  logic [DW-1:0] deint_reg;
  logic          ref_neg_reg;

  wire in_int    = (state_reg == DSS_PH_INT);
  wire in_deint  = (state_reg == DSS_PH_DEINT);
  wire int_end   = count_en && in_int && (cyc_reg == INT_LAST);
  wire at_max    = (deint_reg == DEINT_LAST);
  // Zero crossing stops counting on the tick it is seen
  wire deint_hit = count_en && in_deint && zero_s;
  wire deint_ovr = count_en && in_deint && !zero_s && at_max;
  wire deint_end = deint_hit || deint_ovr;
  wire cyc_end   = count_en && (cyc_reg == CYC_LAST);
  wire bcd_inc   = count_en && in_deint && !zero_s;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DSS_PH_INT:
        if (int_end)
          state_next = DSS_PH_DEINT;
      DSS_PH_DEINT:
        if (deint_end)
          state_next = DSS_PH_AZ;
      DSS_PH_AZ:
        if (cyc_end)
          state_next = DSS_PH_INT;
      default:
        state_next = DSS_PH_AZ;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= DSS_PH_INT;
    else
      state_reg <= state_next;
  end

  // Cycle length is fixed by this counter, not by the phases
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cyc_reg <= '0;
    else if (count_en)
      cyc_reg <= cyc_end ? '0 : cyc_reg + CW'(1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      deint_reg <= '0;
    else if (int_end)
      deint_reg <= '0;
    else if (bcd_inc)
      deint_reg <= deint_reg + DW'(1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ref_neg_reg <= 1'b0;
    else if (int_end)
      ref_neg_reg <= neg_s;
  end

  // Decade counters
  logic [4*DIGITS-1:0] bcd_value;

  dss_bcd_counter #(
    .DIGITS  (DIGITS)
  ) u_count (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (int_end),
    .inc_i   (bcd_inc),
    .value_o (bcd_value)
  );

  // Display latch
  logic [4*DIGITS-1:0] disp_val_reg;
  logic                disp_neg_reg;
  logic                disp_ovr_reg;
  wire                 latch_load = deint_end && !hold_s;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      disp_val_reg <= '0;
    else if (latch_load)
      disp_val_reg <= bcd_value;
  end

  // Sign rides with the reading, so a held display keeps its own sign
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      disp_neg_reg <= 1'b0;
    else if (latch_load)
      disp_neg_reg <= ref_neg_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      disp_ovr_reg <= 1'b0;
    else if (latch_load)
      disp_ovr_reg <= deint_ovr;
  end

  // Decoding; overrange shows a lone one and the sign, with the three digits blank
  logic [6:0] digit_seg [3];

  for (genvar d = 0; d < 3; d++)
  begin : g_dec
    dss_seg_decode u_dec (
      .bcd_i   (disp_val_reg[4*d +: 4]),
      .blank_i (disp_ovr_reg),
      .seg_o   (digit_seg[d])
    );
  end

  // Thousands digit can only be zero or one below full scale
  wire one_on = disp_ovr_reg || (disp_val_reg[4*3 +: 4] != 4'h0);

  dss_seg_t lit;

  assign lit.sign     = disp_neg_reg;
  assign lit.one      = one_on;
  assign lit.hundreds = digit_seg[2];
  assign lit.tens     = digit_seg[1];
  assign lit.units    = digit_seg[0];

  wire [SEGW-1:0] lit_vec = lamp_s ? {SEGW{1'b1}} : lit;

  // Backplane divider
  logic [BW-1:0] bp_cnt_reg;
  logic          bp_reg;
  wire           bp_flip = (bp_cnt_reg == BP_LAST);
  wire           bp_next = bp_flip ? !bp_reg : bp_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bp_cnt_reg <= '0;
    else
      bp_cnt_reg <= bp_flip ? '0 : bp_cnt_reg + BW'(1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bp_reg <= 1'b0;
    else
      bp_reg <= bp_next;
  end

  // Segment drive; XOR with the same backplane keeps DC off the glass
  wire [SEGW-1:0] lcd_drive = lit_vec ^ {SEGW{bp_next}};
  // LED build sinks current, so a lit segment pulls low
  wire [SEGW-1:0] led_drive = ~lit_vec;
  wire [SEGW-1:0] drive     = LCD_VARIANT ? lcd_drive : led_drive;

  dss_ctrl_t ctrl_next;

  assign ctrl_next.auto_zero     = (state_next == DSS_PH_AZ);
  assign ctrl_next.sig_integrate = (state_next == DSS_PH_INT);
  assign ctrl_next.de_integrate  = (state_next == DSS_PH_DEINT);
  assign ctrl_next.ref_negative  = int_end ? neg_s : ref_neg_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      seg_o <= '0;
    else
      seg_o <= drive;
  end

  // Switch controls leave a flop so the analog switches see no glitch
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_o <= '0;
    else
      ctrl_o <= ctrl_next;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      backplane_drive_o <= 1'b0;
    else
      backplane_drive_o <= LCD_VARIANT ? bp_next : 1'b0;
  end
endmodule // dss_top

/* tb/dss_top_props.sv */
module dss_top_props #(
  parameter bit LCD_VARIANT  = 1'b1,
  parameter int PRESCALE     = 4,
  parameter int BP_DIV       = 800,
  parameter int INT_COUNTS   = 1000,
  parameter int DEINT_MAX    = 2000,
  parameter int CYCLE_COUNTS = 4000
) (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic               lamp_test_i,
  input wire logic               hold_reading_input_i,
  input wire logic               integ_zero_i,
  input wire logic               integ_negative_i,
  input wire dss_pkg::dss_ctrl_t ctrl_o,
  input wire dss_pkg::dss_seg_t  seg_o,
  input wire logic               backplane_drive_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;
  localparam int INT_CLK = INT_COUNTS * PRESCALE;
  localparam int CYC     = CYCLE_COUNTS * PRESCALE;
  localparam int DE_CLK  = DEINT_MAX * PRESCALE;
  localparam int ZMAX    = PRESCALE + 4;
  localparam int HALF    = BP_DIV / 2;
  logic [22:0] lit;
  logic        flip;
  logic        rise;
  logic        bp_q;
  logic        int_q;
  logic        seen;
  logic        live;
  logic [1:0]  nrise;
  int          cnt;
  int          int_run;
  int          de_run;
  int          since;
  // Glass view, so both builds share one lamp check
  assign lit  = LCD_VARIANT ? (seg_o ^ {23{backplane_drive_o}}) : ~seg_o;
  assign flip = backplane_drive_o != bp_q;
  assign rise = ctrl_o.sig_integrate && !int_q;
  // Long phases are timed by counters, not by unrolled delays
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bp_q    <= 1'b0;
      int_q   <= 1'b0;
      seen    <= 1'b0;
      live    <= 1'b0;
      nrise   <= 2'h0;
      cnt     <= 0;
      int_run <= 0;
      de_run  <= 0;
      since   <= 0;
    end
    else
    begin
      bp_q    <= backplane_drive_o;
      int_q   <= ctrl_o.sig_integrate;
      seen    <= seen | flip;
      live    <= 1'b1;
      nrise   <= (rise && nrise != 2'h2) ? nrise + 2'h1 : nrise;
      cnt     <= flip ? 0 : cnt + 1;
      int_run <= ctrl_o.sig_integrate ? int_run + 1 : 0;
      de_run  <= ctrl_o.de_integrate ? de_run + 1 : 0;
      since   <= rise ? 1 : since + 1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // First edge after release still sees reset outputs
  property p_one_phase;
    live |-> $onehot({ctrl_o.auto_zero, ctrl_o.sig_integrate,
                      ctrl_o.de_integrate});
  endproperty
  a_one_phase: assert property (p_one_phase)
    else $error("phase bits not one-hot");
  // First integrate after reset is cut short; only whole cycles count
  property p_int_len;
    nrise == 2'h2 && $fell(ctrl_o.sig_integrate) |-> int_run == INT_CLK;
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("integrate length wrong");
  property p_cycle;
    nrise == 2'h2 && rise |-> since == CYC;
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("cycle length wrong");
  property p_deint_max;
    ctrl_o.de_integrate |-> de_run < DE_CLK;
  endproperty
  a_deint_max: assert property (p_deint_max)
    else $error("de-integrate too long");
  property p_zero_stop;
    ctrl_o.de_integrate && integ_zero_i |-> ##[1:ZMAX] ctrl_o.auto_zero;
  endproperty
  a_zero_stop: assert property (p_zero_stop)
    else $error("zero did not end de-integrate");
  property p_led_bp;
    !LCD_VARIANT |-> !backplane_drive_o;
  endproperty
  a_led_bp: assert property (p_led_bp)
    else $error("backplane active in LED build");
  property p_lamp;
    lamp_test_i [*4] |-> lit == 23'h7FFFFF;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp test not all lit");
  property p_bp_half;
    seen && flip |-> cnt == HALF - 1;
  endproperty
  a_bp_half: assert property (p_bp_half)
    else $error("backplane half period wrong");
  c_az: cover property ($rose(ctrl_o.auto_zero));
  c_lamp: cover property (lamp_test_i [*4]);
  c_hold: cover property (hold_reading_input_i && ctrl_o.de_integrate);
endmodule // dss_top_props

bind dss_top dss_top_props #(
  .LCD_VARIANT(LCD_VARIANT), .PRESCALE(PRESCALE), .BP_DIV(BP_DIV),
  .INT_COUNTS(INT_COUNTS), .DEINT_MAX(DEINT_MAX),
  .CYCLE_COUNTS(CYCLE_COUNTS)
) dss_top_props_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .lamp_test_i(lamp_test_i),
  .hold_reading_input_i(hold_reading_input_i),
  .integ_zero_i(integ_zero_i), .integ_negative_i(integ_negative_i),
  .ctrl_o(ctrl_o), .seg_o(seg_o), .backplane_drive_o(backplane_drive_o)
);

/* tb/dss_disp_model.sv */
module dss_disp_model #(
  parameter bit LCD = 1'b1
) (
  input  wire dss_pkg::dss_seg_t seg_i,
  input  wire logic              bp_i,
  output logic            [22:0] lit_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;
  // Glass sees segment against backplane; LED sinks low
  assign lit_o = LCD ? (seg_i ^ {23{bp_i}}) : ~seg_i;
endmodule // dss_disp_model

/* tb/dss_top_tb_top.sv */
module dss_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;
  localparam int PRE = 2;
  localparam int BPD = 8;
  localparam int INTC = 10;
  localparam int DMX = 20;
  localparam int CYC = 40;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        lamp_test_i = 1'b0;
  logic        hold_reading_input_i = 1'b0;
  logic        integ_zero_i = 1'b0;
  logic        integ_negative_i = 1'b0;
  dss_ctrl_t   ctrl_o;
  dss_seg_t    seg_o;
  dss_seg_t    led_seg;
  logic        bp;
  logic [22:0] lit;
  logic [22:0] prev;
  logic [22:0] got;
  logic [22:0] exp_q[$];
  int          bad_count = 0;
  int          num_checks = 0;
  int          md[10] = '{1, 0, 0, 2, 0, 3, 3, 0, 1, 0};

  always #10 clk_i = ~clk_i;

  dss_top #(.PRESCALE(PRE), .BP_DIV(BPD), .INT_COUNTS(INTC),
    .DEINT_MAX(DMX), .CYCLE_COUNTS(CYC)) dss_top_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .lamp_test_i(lamp_test_i),
    .hold_reading_input_i(hold_reading_input_i),
    .integ_zero_i(integ_zero_i), .integ_negative_i(integ_negative_i),
    .ctrl_o(ctrl_o), .seg_o(seg_o), .backplane_drive_o(bp));
  dss_top #(.LCD_VARIANT(1'b0), .PRESCALE(PRE), .BP_DIV(BPD),
    .INT_COUNTS(INTC), .DEINT_MAX(DMX), .CYCLE_COUNTS(CYC)) dss_top_led_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .lamp_test_i(lamp_test_i),
    .hold_reading_input_i(hold_reading_input_i),
    .integ_zero_i(integ_zero_i), .integ_negative_i(integ_negative_i),
    .ctrl_o(), .seg_o(led_seg), .backplane_drive_o());
  dss_disp_model #(.LCD(1'b1)) dss_disp_model_i (
    .seg_i(seg_o), .bp_i(bp), .lit_o(lit));

  function automatic logic [6:0] f7(int d);
    logic [6:0] t[10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66,
                          7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
    return t[d];
  endfunction

  task automatic cmp(logic [22:0] g, logic [22:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic step;
    @(posedge clk_i);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Modes: 0 random zero, 1 zero at once, 2 overrange, 3 held
  task automatic run_cycle(int mode);
    int k;
    int n;
    int c;
    logic [22:0] e;
    integ_negative_i = 1'($urandom_range(1));
    hold_reading_input_i = (mode == 3);
    integ_zero_i = (mode == 1);
    k = $urandom_range(28);
    n = 0;
    while (!ctrl_o.de_integrate)
      step();
    cmp({22'h0, ctrl_o.ref_negative}, {22'h0, integ_negative_i});
    while (!ctrl_o.auto_zero)
    begin
      if (mode == 0 && n == k)
        integ_zero_i = 1'b1;
      n++;
      step();
    end
    integ_zero_i = 1'b0;
    hold_reading_input_i = 1'b0;
    // Zero reaches the counter two clocks late, then waits for a tick
    c = (mode == 0) ? (k + 2) / PRE : 0;
    cmp(23'(n), 23'((mode > 1 ? DMX : c + 1) * PRE));
    case (mode)
      1: e = {integ_negative_i, 1'b0, f7(0), f7(0), f7(0)};
      2: e = {integ_negative_i, 1'b1, 21'h0};
      3: e = prev;
      default: e = {integ_negative_i, 1'b0, f7(0), f7(c / 10), f7(c % 10)};
    endcase
    exp_q.push_back(e);
    prev = e;
  endtask

  initial
  begin
    forever
    begin
      @(posedge ctrl_o.auto_zero);
      step();
      got = exp_q.pop_front();
      cmp(lit, got);
      cmp(~led_seg, got);
    end
  end

  initial
  begin
    void'($urandom(33269));
    repeat (10) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      run_cycle(md[i]);
      $display("cycle %0d mode %0d done", i, md[i]);
    end
    repeat (2) step();
    lamp_test_i = 1'b1;
    repeat (4) step();
    cmp(lit, 23'h7FFFFF);
    cmp(~led_seg, 23'h7FFFFF);
    lamp_test_i = 1'b0;
    repeat (4) step();
    cmp(lit, prev);
    cmp(~led_seg, prev);
    $display("lamp test done");
    tally_and_finish();
  end

  // Ten cycles of 80 clocks need about 850 clocks
  initial
  begin
    #(20 * 2000);
    bad_count++;
    tally_and_finish();
  end
endmodule // dss_top_tb_top
